//--- verilog/csf_cfg.svh
/*
  bit positions, reset values and address constants of the processor status register.
  assumes nothing; included by bare name.
*/
`ifndef CSF_CFG_SVH
`define CSF_CFG_SVH
`define CSF_BIT_C        0
`define CSF_BIT_DC       1
`define CSF_BIT_Z        2
`define CSF_BIT_PD       3
`define CSF_BIT_TO       4
`define CSF_BIT_RP0      5
`define CSF_BIT_RP1      6
`define CSF_BIT_IRP      7
`define CSF_STATUS_LOW   7'h03
`define CSF_POR_BANK     3'h0
`define CSF_POR_FLAGS    2'h3
`define CSF_POR_ALU      3'h0
`define CSF_CLEAR_BANK   3'h0
`define CSF_NIB          4
`endif

//--- verilog/csf_pkg.sv
/*
  types of the processor status register block.
  assumes csf_cfg.svh is on the include path.
*/
package csf_pkg;
  typedef logic [7:0] csf_byte_t;
  typedef enum logic [2:0] {
    CSF_ALU_NONE,
    CSF_ALU_ADD,
    CSF_ALU_SUB,
    CSF_ALU_ROT_LEFT,
    CSF_ALU_ROT_RIGHT,
    CSF_ALU_LOGIC
  } csf_alu_e;
endpackage

//--- verilog/csf_status_reg.sv
/*
  status register of the processor core: alu flags, reset cause and bank selects.
  assumes one core clock, a core that presents one instruction result per cycle on
  wr_en, and watchdog and sleep events as one-cycle pulses from the same clock.
*/
`timescale 1ns/1ps
`include "csf_cfg.svh"

// Contract
// RULE1: any instruction may write the status register like any other file register.
// RULE2: a flag-affecting instruction writing the status register cannot write zero, digit carry or carry; here only the flags it sets are protected.
// RULE3: expiry and powerdown flags ignore instruction writes.
// RULE4: clear-file on the status register zeroes the bank bits and sets zero, keeping the rest.
// RULE5: software should alter the status register only with bit clear, bit set, nibble swap or move from work.
// RULE6: subtraction adds the two's complement, so carry and digit carry act as inverted borrows.
// RULE7: the status register decodes at the same low address in every bank.
// RULE8: the register holds alu flags, reset cause and bank-select bits.
// RULE9: expiry sets on power-up, watchdog clear or sleep, and clears on watchdog time-out.
// RULE10: powerdown sets on power-up or watchdog clear, and clears on sleep.
// RULE11: the two direct bank bits pick one of four 128-byte banks, the indirect bit a bank pair; here dir_addr is 8 bits, so each direct bank is 256 bytes.
// RULE12: carry is the carry out of the top bit, or for rotates the bit shifted out.
module csf_status_reg #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 9
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                por,
  input  wire logic                wr_en,
  input  wire logic [ADDR_W-1:0]   wr_addr,
  input  wire logic [DATA_W-1:0]   wr_data,
  input  wire logic                clear_file_op,
  input  wire csf_pkg::csf_alu_e   alu_op,
  input  wire logic [DATA_W-1:0]   alu_a,
  input  wire logic [DATA_W-1:0]   alu_b,
  input  wire logic                alu_carry_in,
  input  wire logic                watchdog_clear_op,
  input  wire logic                sleep_op,
  input  wire logic                watchdog_timeout,
  input  wire logic [ADDR_W-2:0]   dir_addr,
  input  wire logic [DATA_W-1:0]   ind_addr,
  output logic [DATA_W-1:0]        alu_result,
  output logic [DATA_W-1:0]        status,
  output logic                     status_hit,
  output logic [ADDR_W:0]          direct_full_addr,
  output logic [ADDR_W-1:0]        indirect_full_addr
);

  // ***********************************************
  // helpers
  // ***********************************************
  // carry out lands in the top bit of the result
  function automatic logic [DATA_W:0] add_with_carry(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b,
    input logic              cin
  );
    logic [DATA_W:0] total;
    total = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
    return total;
  endfunction

  // an alu flag beats the written bit
  function automatic logic pick_flag(
    input logic sets,
    input logic alu_val,
    input logic data_val
  );
    return sets ? alu_val : data_val;
  endfunction

  // ***********************************************
  // alu
  // ***********************************************
  logic [DATA_W:0]   sum;
  logic [DATA_W:0]   low_sum;
  logic [DATA_W-1:0] nib_mask;
  logic              alu_c;
  logic              alu_dc;
  logic              alu_z;
  logic              alu_sets_c;
  logic              alu_sets_dc;
  logic              alu_sets_z;

  // low nibble only, for the digit carry
  assign nib_mask = {{(DATA_W-`CSF_NIB){1'b0}}, {`CSF_NIB{1'b1}}};

  always_comb begin
    sum         = '0;
    low_sum     = '0;
    alu_result  = alu_a;
    alu_c       = 1'b0;
    alu_dc      = 1'b0;
    alu_sets_c  = 1'b0;
    alu_sets_dc = 1'b0;
    alu_sets_z  = 1'b0;
    unique case (alu_op)
      csf_pkg::CSF_ALU_NONE: begin
        alu_result = alu_a;
      end
      csf_pkg::CSF_ALU_ADD: begin
        // RULE12 carry out of top
        sum         = add_with_carry(alu_a, alu_b, 1'b0);
        low_sum     = add_with_carry(alu_a & nib_mask, alu_b & nib_mask, 1'b0);
        alu_result  = sum[DATA_W-1:0];
        alu_c       = sum[DATA_W];
        alu_dc      = low_sum[`CSF_NIB];
        alu_sets_c  = 1'b1;
        alu_sets_dc = 1'b1;
        alu_sets_z  = 1'b1;
      end
      csf_pkg::CSF_ALU_SUB: begin
        // RULE6 add two's complement
        sum         = add_with_carry(alu_a, ~alu_b, 1'b1);
        low_sum     = add_with_carry(alu_a & nib_mask, ~alu_b & nib_mask, 1'b1);
        alu_result  = sum[DATA_W-1:0];
        alu_c       = sum[DATA_W];
        alu_dc      = low_sum[`CSF_NIB];
        alu_sets_c  = 1'b1;
        alu_sets_dc = 1'b1;
        alu_sets_z  = 1'b1;
      end
      csf_pkg::CSF_ALU_ROT_LEFT: begin
        // RULE12 rotate bit out
        alu_result = {alu_a[DATA_W-2:0], alu_carry_in};
        alu_c      = alu_a[DATA_W-1];
        alu_sets_c = 1'b1;
      end
      csf_pkg::CSF_ALU_ROT_RIGHT: begin
        alu_result = {alu_carry_in, alu_a[DATA_W-1:1]};
        alu_c      = alu_a[0];
        alu_sets_c = 1'b1;
      end
      csf_pkg::CSF_ALU_LOGIC: begin
        alu_result = alu_b;
        alu_sets_z = 1'b1;
      end
      default: begin
        alu_result = alu_a;
      end
    endcase
    alu_z = (alu_result == '0);
  end

  // ***********************************************
  // address decode
  // ***********************************************
  // RULE7 any bank hits
  assign status_hit = (dir_addr == (ADDR_W-1)'(`CSF_STATUS_LOW));

  // ***********************************************
  // status register
  // ***********************************************
  logic [DATA_W-1:0] status_q;
  logic [DATA_W-1:0] status_d;
  logic              wr_hit;

  assign wr_hit = wr_en && status_hit;

  always_comb begin
    status_d = status_q;
    if (wr_hit && clear_file_op) begin
      // RULE4 clear-file form
      status_d[`CSF_BIT_IRP] = 1'b0;
      status_d[`CSF_BIT_RP1] = 1'b0;
      status_d[`CSF_BIT_RP0] = 1'b0;
      status_d[`CSF_BIT_Z]   = 1'b1;
    end else if (wr_hit) begin
      // RULE1 plain write
      status_d[`CSF_BIT_IRP] = wr_data[`CSF_BIT_IRP];
      status_d[`CSF_BIT_RP1] = wr_data[`CSF_BIT_RP1];
      status_d[`CSF_BIT_RP0] = wr_data[`CSF_BIT_RP0];
      // RULE2 alu flags win
      status_d[`CSF_BIT_Z]   = pick_flag(alu_sets_z, alu_z, wr_data[`CSF_BIT_Z]);
      status_d[`CSF_BIT_DC]  = pick_flag(alu_sets_dc, alu_dc, wr_data[`CSF_BIT_DC]);
      status_d[`CSF_BIT_C]   = pick_flag(alu_sets_c, alu_c, wr_data[`CSF_BIT_C]);
    end else if (wr_en) begin
      // RULE8 alu flags tracked
      if (alu_sets_z) begin
        status_d[`CSF_BIT_Z] = alu_z;
      end
      if (alu_sets_dc) begin
        status_d[`CSF_BIT_DC] = alu_dc;
      end
      if (alu_sets_c) begin
        status_d[`CSF_BIT_C] = alu_c;
      end
    end
    // RULE3 reset-cause read-only
    // RULE9 expiry flag events
    if (watchdog_timeout) begin
      status_d[`CSF_BIT_TO] = 1'b0;
    end else if (watchdog_clear_op || sleep_op) begin
      status_d[`CSF_BIT_TO] = 1'b1;
    end
    // RULE10 powerdown flag events
    if (sleep_op) begin
      status_d[`CSF_BIT_PD] = 1'b0;
    end else if (watchdog_clear_op) begin
      status_d[`CSF_BIT_PD] = 1'b1;
    end
  end

  // ***********************************************
  // register and resets
  // ***********************************************
  always_ff @(posedge ref_clk) begin
    if (rst && por) begin
      status_q <= {`CSF_POR_BANK, `CSF_POR_FLAGS, `CSF_POR_ALU};
    end else if (rst) begin
      status_q <= {`CSF_CLEAR_BANK, status_q[`CSF_BIT_TO:0]};
    end else begin
      status_q <= status_d;
    end
  end

  assign status = status_q;

  // ***********************************************
  // bank selection
  // ***********************************************
  // RULE11 bank composition
  assign direct_full_addr   = {status_q[`CSF_BIT_RP1], status_q[`CSF_BIT_RP0], dir_addr};
  assign indirect_full_addr = {status_q[`CSF_BIT_IRP], ind_addr};

endmodule // csf_status_reg

//--- tb/csf_status_properties.sv
/* status register assertions; assumes a bind from the bench top and one clock. */
`timescale 1ns/1ps
module csf_status_props (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       wr_en,
  input wire logic [7:0] wr_data,
  input wire logic       clear_file_op,
  input wire logic       watchdog_clear_op,
  input wire logic       sleep_op,
  input wire logic       watchdog_timeout,
  input wire logic [7:0] dir_addr,
  input wire logic [7:0] status,
  input wire logic       status_hit,
  input wire logic [9:0] direct_full_addr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    !watchdog_timeout && !sleep_op && !watchdog_clear_op;
  endsequence
  sequence s_clear;
    s_quiet ##0 (wr_en && clear_file_op && status_hit);
  endsequence
  chk_clear_file: assert property (s_clear |=> status == (($past(status) & 8'h1b) | 8'h04))
    else $error("clear");
  chk_ro_bits: assert property (s_quiet |=> $stable(status[4:3])) else $error("ro bits");
  chk_sleep_set: assert property (sleep_op && !watchdog_timeout |=> status[4:3] == 2'h2)
    else $error("sleep");
  chk_time_out: assert property (watchdog_timeout |=> !status[4]) else $error("timeout");
  chk_wdt_set: assert property (watchdog_clear_op && !sleep_op && !watchdog_timeout |=> status[4:3] == 2'h3)
    else $error("wdt");
  chk_hit_addr: assert property (status_hit == (dir_addr == 8'h03)) else $error("hit");
  chk_bank_addr: assert property (direct_full_addr == {status[6:5], dir_addr}) else $error("bank");
  chk_bank_wr: assert property (
    wr_en && status_hit && !clear_file_op |=> status[7:5] == $past(wr_data[7:5])) else $error("write");
endmodule // csf_status_props

//--- tb/csf_status_reg_tb_top.sv
/* status register bench; assumes package, design and checker compiled first. */
`timescale 1ns/1ps
module csf_status_reg_tb_top;
  logic              ref_clk = 1'b0;
  logic [6:0]        ctl = 7'h60;
  logic [7:0]        dir_addr, wr_data, ind_addr, alu_a, alu_b, status, alu_result;
  logic              status_hit;
  logic [9:0]        direct_full_addr;
  logic [8:0]        indirect_full_addr;
  csf_pkg::csf_alu_e alu_op = csf_pkg::CSF_ALU_NONE;
  int                n_mismatch = 0;
  int                n_compared = 0;
  always #5 ref_clk = ~ref_clk;
  // ctl bits: write, clear-file, watchdog clear, sleep, time-out, reset, power-on
  csf_status_reg uut (.ref_clk, .rst(ctl[5]), .por(ctl[6]), .wr_en(ctl[0]), .wr_addr(9'h003), .wr_data,
    .clear_file_op(ctl[1]), .alu_op, .alu_a, .alu_b, .alu_carry_in(status[0]), .watchdog_clear_op(ctl[2]),
    .sleep_op(ctl[3]), .watchdog_timeout(ctl[4]), .dir_addr, .ind_addr, .alu_result, .status,
    .status_hit, .direct_full_addr, .indirect_full_addr);
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %h, not %h", $time, g, e);
    end
  endtask
  task automatic step(input logic [15:0] w, input logic [6:0] c, input logic [7:0] e,
                      input csf_pkg::csf_alu_e op = csf_pkg::CSF_ALU_NONE, input logic [15:0] ab = 16'h0000);
    @(posedge ref_clk);
    {dir_addr, wr_data, ind_addr, alu_a, alu_b, ctl} <= {w, w[7:0], ab, c};
    alu_op <= op;
    @(posedge ref_clk);
    ctl <= 7'h00;
    #1;
    chk({2'h0, status}, {2'h0, e});
  endtask
  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic t_write;
    chk({2'h0, status}, 10'h018);
    step(16'h03ff, 7'h01, 8'hff);
    step(16'h0300, 7'h01, 8'h18);
    step(16'h03e5, 7'h01, 8'hfd);
    step(16'h0300, 7'h03, 8'h1d);
    $display("write done");
  endtask
  task automatic t_flags;
    step(16'h0307, 7'h01, 8'h1a, csf_pkg::CSF_ALU_ADD, 16'h0f01);
    chk({2'h0, alu_result}, 10'h010);
    step(16'h2000, 7'h01, 8'h1b, csf_pkg::CSF_ALU_ROT_LEFT, 16'h8000);
    chk({2'h0, alu_result}, 10'h001);
    step(16'h2000, 7'h01, 8'h19, csf_pkg::CSF_ALU_SUB, 16'h1001);
    chk({2'h0, alu_result}, 10'h00f);
    step(16'h2000, 7'h08, 8'h11);
    step(16'h2000, 7'h10, 8'h01);
    step(16'h2000, 7'h04, 8'h19);
    step(16'h2000, 7'h01, 8'h18, csf_pkg::CSF_ALU_ROT_RIGHT, 16'h0200);
    chk({2'h0, alu_result}, 10'h001);
    step(16'h2000, 7'h01, 8'h1c, csf_pkg::CSF_ALU_LOGIC, 16'h0000);
    chk({2'h0, alu_result}, 10'h000);
    $display("flags done");
  endtask
  task automatic t_bank;
    step(16'h03e5, 7'h01, 8'hfd);
    chk({9'h000, status_hit}, 10'h001);
    step(16'h0534, 7'h00, 8'hfd);
    chk(direct_full_addr, 10'h305);
    chk({1'b0, indirect_full_addr}, 10'h134);
    chk({9'h000, status_hit}, 10'h000);
    step(16'h0534, 7'h20, 8'h1d);
    $display("bank done");
  endtask
  initial begin
    {dir_addr, wr_data, ind_addr, alu_a, alu_b} = 40'h00;
    repeat (2) @(posedge ref_clk);
    ctl <= 7'h00;
    #1;
    t_write;
    t_flags;
    t_bank;
    end_of_test;
  end
  initial begin
    #2000;
    n_mismatch++;
    end_of_test;
  end
endmodule // csf_status_reg_tb_top
bind csf_status_reg csf_status_props chk_i (.ref_clk(ref_clk), .rst(rst), .wr_en(wr_en), .wr_data(wr_data),
  .clear_file_op(clear_file_op), .watchdog_clear_op(watchdog_clear_op), .sleep_op(sleep_op),
  .watchdog_timeout(watchdog_timeout), .dir_addr(dir_addr), .status(status), .status_hit(status_hit),
  .direct_full_addr(direct_full_addr));
